// ---- hw/external_bus_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_bus_controller
  import ext_bus_pkg::*;
#(
  parameter int NUM_WINDOWS = 4
) (
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset,
  // cpu request side
  input  wire logic                                     req_valid,
  output logic                                          req_ready,
  input  wire logic [ADDR_W-1:0]                        req_addr,
  input  wire logic                                     req_write,
  input  wire logic                                     req_byte,
  input  wire logic [DATA_W-1:0]                        req_wdata,
  output logic                                          resp_valid,
  output logic                                          resp_internal,
  output logic [DATA_W-1:0]                             resp_rdata,
  // configuration bits
  input  wire ext_bus_pkg::bus_cfg_t                    default_bus_config,
  input  wire ext_bus_pkg::bus_cfg_t [NUM_WINDOWS-1:0]  window_bus_config,
  input  wire logic [NUM_WINDOWS-1:0][RANGE_W-1:0]      window_range_base,
  input  wire logic [NUM_WINDOWS-1:0][RANGE_W-1:0]      window_range_mask,
  input  wire logic                                     write_pin_config,
  input  wire logic                                     byte_pin_disable_we,
  input  wire logic                                     byte_pin_disable_wdata,
  output logic                                          byte_pin_disable,
  output logic [1:0]                                    segment_line_select,
  output logic [1:0]                                    chip_select_count,
  // reset straps
  input  wire logic [1:0]                               strap_segment_sel,
  input  wire logic [1:0]                               strap_cs_count,
  input  wire logic                                     strap_bus16,
  // external bus pins
  output logic                                          address_latch_enable,
  output logic                                          read_strobe_n,
  output logic                                          write_low_strobe_n,
  output logic                                          byte_high_enable_out,
  output logic                                          byte_high_enable_oe,
  input  wire logic [DATA_W-1:0]                        mux_data_port_in,
  output logic [DATA_W-1:0]                             mux_data_port_out,
  output logic [DATA_W-1:0]                             mux_data_port_oe,
  output logic [15:0]                                   address_port_out,
  output logic [15:0]                                   address_port_oe,
  output logic [7:0]                                    segment_port_out,
  output logic [7:0]                                    segment_port_oe,
  output logic [4:0]                                    window_chip_select_n,
  output logic [4:0]                                    window_chip_select_oe
);
  import ext_bus_pkg::*;

  initial begin
    if (NUM_WINDOWS < 1 || NUM_WINDOWS > 4) begin
      $error("external_bus_controller: NUM_WINDOWS must be 1 to 4");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup functions for reset-latched codes
  function automatic logic [7:0] seg_mask(input logic [1:0] code);
    case (code)
      SEG_TWO:   seg_mask = SEG_MASK_TWO;
      SEG_EIGHT: seg_mask = SEG_MASK_EIGHT;
      SEG_NONE:  seg_mask = SEG_MASK_NONE;
      default:   seg_mask = SEG_MASK_FOUR;
    endcase
  endfunction : seg_mask

  function automatic logic [4:0] cs_mask(input logic [1:0] code);
    case (code)
      CSC_FIVE: cs_mask = CS_MASK_FIVE;
      CSC_NONE: cs_mask = CS_MASK_NONE;
      CSC_TWO:  cs_mask = CS_MASK_TWO;
      default:  cs_mask = CS_MASK_THREE;
    endcase
  endfunction : cs_mask

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0]        strap_seg_s1, strap_seg_s2;
  logic [1:0]        strap_cs_s1, strap_cs_s2;
  logic              strap_bus16_s1, strap_bus16_s2;
  logic [DATA_W-1:0] data_in_s1, data_in_s2;

  always_ff @(posedge clk_sys) begin
    strap_seg_s1   <= strap_segment_sel;
    strap_seg_s2   <= strap_seg_s1;
    strap_cs_s1    <= strap_cs_count;
    strap_cs_s2    <= strap_cs_s1;
    strap_bus16_s1 <= strap_bus16;
    strap_bus16_s2 <= strap_bus16_s1;
    data_in_s1     <= mux_data_port_in;
    data_in_s2     <= data_in_s1;
  end

  // chip select code latched at reset
  // byte pin disable from width strap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      segment_line_select <= strap_seg_s2;
      chip_select_count   <= strap_cs_s2;
      byte_pin_disable    <= ~strap_bus16_s2;
    end else if (byte_pin_disable_we) begin
      byte_pin_disable    <= byte_pin_disable_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window lookup of the incoming request
  window_lookup_if look ();

  assign look.addr = req_addr;

  window_decoder #(
    .NUM_WINDOWS (NUM_WINDOWS)
  ) u_decoder (
    .look              (look),
    .window_bus_config (window_bus_config),
    .window_range_base (window_range_base),
    .window_range_mask (window_range_mask)
  );

  // configuration of each chip select index, 0 is the default
  bus_cfg_t [4:0] cfg_by_index;
  logic           any_demux;

  for (genvar i = 0; i < 5; i++) begin : g_cfg
    if (i == 0) begin : g_def
      assign cfg_by_index[i] = default_bus_config;
    end else if (i <= NUM_WINDOWS) begin : g_win
      assign cfg_by_index[i] = window_bus_config[i-1];
    end else begin : g_none
      assign cfg_by_index[i] = '0;
    end
  end

  // demux anywhere keeps the address port
  assign any_demux = |{default_bus_config.enable & default_bus_config.demux,
                       (cfg_by_index[4].enable & cfg_by_index[4].demux),
                       (cfg_by_index[3].enable & cfg_by_index[3].demux),
                       (cfg_by_index[2].enable & cfg_by_index[2].demux),
                       (cfg_by_index[1].enable & cfg_by_index[1].demux)};

  ////////////////////////////////////////////////////////////////////////////
  // cycle registers
  state_t            state, next_state;
  logic [ADDR_W-1:0] cyc_addr;
  logic              cyc_write;
  logic              cyc_byte;
  logic [DATA_W-1:0] cyc_wdata;
  bus_cfg_t          cyc_cfg;
  logic [2:0]        cyc_win;
  logic              cyc_switch;
  logic              cyc_second;
  logic [1:0]        cmd_cnt;
  logic [2:0]        cs_area;
  logic              cs_area_valid;
  logic [DATA_W-1:0] rdata;
  logic              resp_pulse;
  logic              resp_int_pulse;

  // decoded conditions of the running cycle
  logic start_ext, start_int, cmd_done, split_word, last_byte;
  logic in_cmd, in_ale, lo_sel, hi_sel;

  assign start_ext  = (state == ST_IDLE) && req_valid && !look.is_internal;
  assign start_int  = (state == ST_IDLE) && req_valid && look.is_internal;
  assign in_cmd     = (state == ST_CMD);
  assign in_ale     = (state == ST_ALE) || (state == ST_ALE_EXT);
  assign cmd_done   = in_cmd && (cmd_cnt == CMD_LAST);
  // 8-bit word needs two byte cycles
  assign split_word = !cyc_cfg.bus16 && !cyc_byte;
  assign last_byte  = !split_word || cyc_second;
  // lane selects from size and bit zero
  assign lo_sel     = !cyc_cfg.bus16 || !cyc_byte || !cyc_addr[0];
  assign hi_sel     = cyc_cfg.bus16 && (!cyc_byte || cyc_addr[0]);

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ext) begin
          next_state = ST_ALE;
        end
      end
      ST_ALE: begin
        // extra strobe cycle on demux to mux
        next_state = cyc_switch ? ST_ALE_EXT : ST_CMD;
      end
      ST_ALE_EXT: begin
        next_state = ST_CMD;
      end
      ST_CMD: begin
        if (cmd_done) begin
          next_state = last_byte ? ST_IDLE : ST_ALE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request captured with its own window
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cyc_addr   <= '0;
      cyc_write  <= 1'b0;
      cyc_byte   <= 1'b0;
      cyc_wdata  <= '0;
      cyc_cfg    <= '0;
      cyc_win    <= WIN_DEFAULT;
      cyc_switch <= 1'b0;
      cyc_second <= 1'b0;
    end else if (start_ext) begin
      cyc_addr   <= req_addr;
      cyc_write  <= req_write;
      cyc_byte   <= req_byte;
      cyc_wdata  <= req_wdata;
      cyc_cfg    <= cfg_by_index[look.sel];
      cyc_win    <= look.sel;
      cyc_switch <= !cfg_by_index[look.sel].demux && any_demux;
      cyc_second <= 1'b0;
    end else if (cmd_done && !last_byte) begin
      cyc_addr   <= {cyc_addr[ADDR_W-1:1], 1'b1};
      cyc_second <= 1'b1;
    end
  end

  // command phase length counter
  always_ff @(posedge clk_sys) begin
    if (reset || !in_cmd) begin
      cmd_cnt <= '0;
    end else begin
      cmd_cnt <= cmd_cnt + 2'h1;
    end
  end

  // address select moves at strobe fall
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_area       <= WIN_DEFAULT;
      cs_area_valid <= 1'b0;
    end else if (in_ale && next_state == ST_CMD) begin
      cs_area       <= cyc_win;
      cs_area_valid <= 1'b1;
    end else if (start_int) begin
      cs_area_valid <= 1'b0;
    end
  end

  // byte reads keep the addressed byte and drop the other; word reads keep both
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= '0;
    end else if (start_ext) begin
      rdata <= '0;
    end else if (cmd_done && !cyc_write) begin
      if (split_word) begin
        if (cyc_second) begin
          rdata[15:8] <= data_in_s2[7:0];
        end else begin
          rdata[7:0]  <= data_in_s2[7:0];
        end
      end else if (cyc_byte && cyc_cfg.bus16) begin
        rdata <= {8'h00, cyc_addr[0] ? data_in_s2[15:8] : data_in_s2[7:0]};
      end else if (cyc_byte) begin
        rdata <= {8'h00, data_in_s2[7:0]};
      end else begin
        rdata <= data_in_s2;
      end
    end
  end

  // answer pulses to the cpu
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      resp_pulse     <= 1'b0;
      resp_int_pulse <= 1'b0;
    end else begin
      resp_pulse     <= (cmd_done && last_byte) || start_int;
      resp_int_pulse <= start_int;
    end
  end

  assign req_ready     = (state == ST_IDLE);
  assign resp_valid    = resp_pulse;
  assign resp_internal = resp_int_pulse;
  assign resp_rdata    = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  logic       addr_on_mux, drive_data;
  logic [7:0] wbyte;

  assign address_latch_enable = in_ale;
  // mux address waits for second strobe cycle when cyc_switch is set
  assign addr_on_mux = !cyc_cfg.demux &&
                       (((state == ST_ALE) && !cyc_switch) || (state == ST_ALE_EXT));
  assign drive_data  = in_cmd && cyc_write;
  assign wbyte       = cyc_second ? cyc_wdata[15:8] : cyc_wdata[7:0];

  // 8-bit bus data uses the low byte only; the mux address phase drives all 16 lines
  assign mux_data_port_out = addr_on_mux ? cyc_addr[15:0] :
                             !cyc_cfg.bus16 ? {8'h00, wbyte} :
                             cyc_byte ? {cyc_wdata[7:0], cyc_wdata[7:0]} : cyc_wdata;
  assign mux_data_port_oe  = addr_on_mux ? 16'hFFFF :
                             !drive_data ? 16'h0000 :
                             cyc_cfg.bus16 ? 16'hFFFF : 16'h00FF;

  assign address_port_out = cyc_addr[15:0];
  assign address_port_oe  = any_demux ? 16'hFFFF : 16'h0000;

  // segment lines above the 16-bit address
  assign segment_port_out = cyc_addr[23:16];
  assign segment_port_oe  = seg_mask(segment_line_select);

  assign read_strobe_n        = !(in_cmd && !cyc_write);
  assign write_low_strobe_n   = write_pin_config ? !(drive_data && lo_sel) : !drive_data;
  assign byte_high_enable_out = write_pin_config ? !(drive_data && hi_sel)
                                                 : !((state != ST_IDLE) && hi_sel);
  assign byte_high_enable_oe  = !byte_pin_disable;

  ////////////////////////////////////////////////////////////////////////////
  // chip selects per window index
  logic [4:0] cs_active;
  logic [4:0] cs_pins;

  assign cs_pins = cs_mask(chip_select_count);

  for (genvar i = 0; i < 5; i++) begin : g_cs
    logic       area_hit;
    logic [1:0] mode;
    assign area_hit = cs_area_valid && (cs_area == 3'(i));
    assign mode     = {cfg_by_index[i].cs_write_en, cfg_by_index[i].cs_read_en};
    // mode from write and read enables
    assign cs_active[i] = (mode == CSM_ADDRESS) ? area_hit :
                          (mode == CSM_READ)    ? area_hit && in_cmd && !cyc_write :
                          (mode == CSM_WRITE)   ? area_hit && drive_data :
                                                  area_hit && in_cmd;
    assign window_chip_select_n[i]  = !cs_active[i];
    assign window_chip_select_oe[i] = cs_pins[i];
  end

endmodule : external_bus_controller
`default_nettype wire

// ---- hw/ext_bus_pkg.sv ----
`default_nettype none
package ext_bus_pkg;

  // address and data widths of the external bus
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int RANGE_W = 12;  // window ranges compare address bits 23..12

  // internal area: no external cycle, no chip select
  localparam logic [23:0] INTERNAL_FIRST = 24'h00F000;
  localparam logic [23:0] INTERNAL_LAST  = 24'h00FFFF;

  // window index of the default configuration
  localparam logic [2:0] WIN_DEFAULT = 3'h0;

  // segment line select codes and their segment pin masks
  localparam logic [1:0] SEG_TWO   = 2'h3;
  localparam logic [1:0] SEG_EIGHT = 2'h2;
  localparam logic [1:0] SEG_NONE  = 2'h1;
  localparam logic [1:0] SEG_FOUR  = 2'h0;
  localparam logic [7:0] SEG_MASK_TWO   = 8'h03;
  localparam logic [7:0] SEG_MASK_EIGHT = 8'hFF;
  localparam logic [7:0] SEG_MASK_NONE  = 8'h00;
  localparam logic [7:0] SEG_MASK_FOUR  = 8'h0F;

  // chip select count codes and their chip select pin masks
  localparam logic [1:0] CSC_FIVE  = 2'h3;
  localparam logic [1:0] CSC_NONE  = 2'h2;
  localparam logic [1:0] CSC_TWO   = 2'h1;
  localparam logic [1:0] CSC_THREE = 2'h0;
  localparam logic [4:0] CS_MASK_FIVE  = 5'h1F;
  localparam logic [4:0] CS_MASK_NONE  = 5'h00;
  localparam logic [4:0] CS_MASK_TWO   = 5'h03;
  localparam logic [4:0] CS_MASK_THREE = 5'h07;

  // chip select modes, {write enable, read enable}
  localparam logic [1:0] CSM_ADDRESS = 2'h0;
  localparam logic [1:0] CSM_READ    = 2'h1;
  localparam logic [1:0] CSM_WRITE   = 2'h2;
  localparam logic [1:0] CSM_RDWR    = 2'h3;

  // unused codes; reset latches strap_segment_sel and strap_cs_count instead
  localparam logic [1:0] SEG_SEL_RESET  = SEG_TWO;
  localparam logic [1:0] CS_COUNT_RESET = CSC_FIVE;

  // command phase length; covers the two-stage data input synchroniser
  localparam int          CMD_CYCLES = 3;
  localparam logic [1:0]  CMD_LAST   = 2'(CMD_CYCLES - 1);

  // one bus configuration
  typedef struct packed {
    logic enable;        // window in use
    logic demux;         // 1: demultiplexed, 0: multiplexed
    logic bus16;         // 1: 16-bit data bus, 0: 8-bit
    logic cs_write_en;   // chip_select_write_enable
    logic cs_read_en;    // chip_select_read_enable
  } bus_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALE,
    ST_ALE_EXT,
    ST_CMD
  } state_t;

endpackage : ext_bus_pkg
`default_nettype wire

// ---- hw/window_lookup_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// address in, selected window and internal flag out
interface window_lookup_if;
  logic [23:0] addr;
  logic [2:0]  sel;
  logic        is_internal;

  modport requester (output addr, input sel, input is_internal);
  modport decoder   (input addr, output sel, output is_internal);
endinterface : window_lookup_if
`default_nettype wire

// ---- hw/window_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module window_decoder
  import ext_bus_pkg::*;
#(
  parameter int NUM_WINDOWS = 4
) (
  window_lookup_if.decoder                              look,
  input  wire ext_bus_pkg::bus_cfg_t [NUM_WINDOWS-1:0]  window_bus_config,
  input  wire logic [NUM_WINDOWS-1:0][RANGE_W-1:0]      window_range_base,
  input  wire logic [NUM_WINDOWS-1:0][RANGE_W-1:0]      window_range_mask
);
  import ext_bus_pkg::*;

  initial begin
    if (NUM_WINDOWS < 1 || NUM_WINDOWS > 4) begin
      $error("window_decoder: NUM_WINDOWS must be 1 to 4");
    end
  end

  logic [NUM_WINDOWS-1:0] hit;
  logic [2:0]             pick;

  ////////////////////////////////////////////////////////////////////////////
  // per-window compare of the masked upper address bits
  for (genvar i = 0; i < NUM_WINDOWS; i++) begin : g_hit
    assign hit[i] = window_bus_config[i].enable &&
      (((look.addr[23:12] ^ window_range_base[i]) & window_range_mask[i]) == 12'h000);
  end

  always_comb begin
    pick = WIN_DEFAULT;
    for (int i = 0; i < NUM_WINDOWS; i++) begin
      if (hit[i]) begin
        pick = 3'(i + 1);  // higher window overrides lower
      end
    end
  end

  assign look.is_internal = (look.addr >= INTERNAL_FIRST) && (look.addr <= INTERNAL_LAST);
  assign look.sel         = pick;

endmodule : window_decoder
`default_nettype wire

// ---- bench/ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        read_strobe_n,
  input  wire logic [15:0] address_port_out,
  output logic      [15:0] mux_data_port_in
);
  logic [15:0] junk = 16'hA5A5;
  // released bus shows a changing pattern
  always_ff @(posedge clk_sys) begin
    junk <= ~junk ^ 16'h0101;
  end
  // read data derives from the address lines
  assign mux_data_port_in = read_strobe_n ? junk : (address_port_out ^ 16'h5A3C);
endmodule : ext_mem_model
`default_nettype wire

// ---- bench/external_bus_controller_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_bus_controller_checker
  import ext_bus_pkg::*;
#(
  parameter int NUM_WINDOWS = 4
) (
  input wire logic                                    clk_sys,
  input wire logic                                    reset,
  input wire logic                                    req_valid,
  input wire logic                                    req_ready,
  input wire logic [ADDR_W-1:0]                       req_addr,
  input wire logic                                    req_write,
  input wire logic                                    req_byte,
  input wire logic                                    resp_valid,
  input wire logic                                    resp_internal,
  input wire ext_bus_pkg::bus_cfg_t                   default_bus_config,
  input wire ext_bus_pkg::bus_cfg_t [NUM_WINDOWS-1:0] window_bus_config,
  input wire logic                                    byte_pin_disable,
  input wire logic [1:0]                              segment_line_select,
  input wire logic [1:0]                              chip_select_count,
  input wire logic                                    address_latch_enable,
  input wire logic                                    write_low_strobe_n,
  input wire logic                                    byte_high_enable_oe,
  input wire logic [DATA_W-1:0]                       mux_data_port_out,
  input wire logic [DATA_W-1:0]                       mux_data_port_oe,
  input wire logic [15:0]                             address_port_oe,
  input wire logic [7:0]                              segment_port_oe,
  input wire logic [4:0]                              window_chip_select_n,
  input wire logic [4:0]                              window_chip_select_oe
);
  logic       any_demux;
  logic       byte_wr;
  logic [7:0] seg_mask;
  logic [4:0] cs_mask;
  wire        take     = req_valid & req_ready;
  wire        take_int = take & (req_addr >= INTERNAL_FIRST) & (req_addr <= INTERNAL_LAST);
  // demux seen in any enabled configuration
  always_comb begin
    any_demux = default_bus_config.enable & default_bus_config.demux;
    for (int i = 0; i < NUM_WINDOWS; i++) begin
      any_demux = any_demux | (window_bus_config[i].enable & window_bus_config[i].demux);
    end
  end
  // pin masks from the latched codes
  assign seg_mask = (segment_line_select == SEG_TWO) ? 8'h03 :
                    (segment_line_select == SEG_EIGHT) ? 8'hFF :
                    (segment_line_select == SEG_NONE) ? 8'h00 : 8'h0F;
  assign cs_mask  = (chip_select_count == CSC_FIVE) ? 5'h1F :
                    (chip_select_count == CSC_NONE) ? 5'h00 :
                    (chip_select_count == CSC_TWO) ? 5'h03 : 5'h07;
  // remembers a byte write in flight
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      byte_wr <= 1'b0;
    end else if (take) begin
      byte_wr <= req_write & req_byte;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_take_ext;
    take && !take_int;
  endsequence
  sequence s_ale_done;
    address_latch_enable ##[1:2] !address_latch_enable;
  endsequence
  AST_BHE_OE: assert property (byte_high_enable_oe == !byte_pin_disable)
    else $error("high enable pin drive disagrees with disable bit");
  AST_ADDR_FREE: assert property (!any_demux |-> address_port_oe == 16'h0000)
    else $error("address port driven with no demux configuration");
  AST_ADDR_DRIVE: assert property (any_demux && address_latch_enable |-> address_port_oe == 16'hFFFF)
    else $error("address port not driven in external cycle");
  AST_SEG_OE: assert property (segment_port_oe == seg_mask)
    else $error("segment line drive disagrees with select code");
  AST_CS_OE: assert property (window_chip_select_oe == cs_mask)
    else $error("chip select drive disagrees with count code");
  AST_INT_RESP: assert property (take_int |=> resp_valid && resp_internal && !address_latch_enable)
    else $error("internal access not answered next cycle");
  AST_INT_NO_CS: assert property (take_int |=> ##[0:1] (window_chip_select_n | ~window_chip_select_oe) == 5'h1F)
    else $error("chip select active for internal access");
  AST_EXT_ALE: assert property (s_take_ext |=> s_ale_done)
    else $error("external cycle without one or two latch enable cycles");
  AST_BYTE_BOTH: assert property (byte_wr && !address_latch_enable && mux_data_port_oe == 16'hFFFF |-> mux_data_port_out[15:8] == mux_data_port_out[7:0])
    else $error("byte write not on both halves");
  AST_WRL_LANE: assert property (!write_low_strobe_n |-> mux_data_port_oe[7:0] == 8'hFF)
    else $error("write low strobe without low data lane driven");
endmodule : external_bus_controller_checker
bind external_bus_controller external_bus_controller_checker #(.NUM_WINDOWS(NUM_WINDOWS)) chk_u (
  .clk_sys, .reset, .req_valid, .req_ready, .req_addr, .req_write, .req_byte, .resp_valid,
  .resp_internal, .default_bus_config, .window_bus_config, .byte_pin_disable,
  .segment_line_select, .chip_select_count, .address_latch_enable, .write_low_strobe_n,
  .byte_high_enable_oe, .mux_data_port_out, .mux_data_port_oe, .address_port_oe,
  .segment_port_oe, .window_chip_select_n, .window_chip_select_oe);
`default_nettype wire

// ---- bench/external_bus_window_select_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module external_bus_window_select_tb;
  import ext_bus_pkg::*;
  logic             clk_sys, reset, req_valid, req_write, req_byte, bpd_we, wpc;
  logic             req_ready, resp_valid, resp_int, ale, rd_n, bpd;
  logic [23:0]      req_addr;
  logic [15:0]      req_wdata, port_in, rdata, aout;
  logic [1:0]       seg_sel, csc;
  logic [7:0]       seg_out;
  logic [4:0]       cs_n;
  logic [45:0]      nt;
  logic [45:0]      notes[$];
  bus_cfg_t         dflt;
  bus_cfg_t [3:0]   wcfg;
  logic [3:0][11:0] wbase, wmask;
  int               miscompares, checks_done, seed;
  logic [23:0] base[6] = '{24'h300000, 24'h180000, 24'h110000, 24'h400000, 24'h200000, 24'h00F000};
  logic [4:0]  cse[6]  = '{5'h1E, 5'h1D, 5'h1B, 5'h1F, 5'h0F, 5'h1F};
  external_bus_controller dut_u (.clk_sys, .reset, .req_valid, .req_ready, .req_addr, .req_write,
    .req_byte, .req_wdata, .resp_valid, .resp_internal(resp_int), .resp_rdata(rdata),
    .default_bus_config(dflt), .window_bus_config(wcfg), .window_range_base(wbase),
    .window_range_mask(wmask), .write_pin_config(wpc), .byte_pin_disable_we(bpd_we),
    .byte_pin_disable_wdata(1'b1), .byte_pin_disable(bpd), .segment_line_select(seg_sel),
    .chip_select_count(csc), .strap_segment_sel(2'h2), .strap_cs_count(2'h3), .strap_bus16(1'b1),
    .address_latch_enable(ale), .read_strobe_n(rd_n), .write_low_strobe_n(),
    .byte_high_enable_out(), .byte_high_enable_oe(), .mux_data_port_in(port_in),
    .mux_data_port_out(), .mux_data_port_oe(), .address_port_out(aout), .address_port_oe(),
    .segment_port_out(seg_out), .segment_port_oe(), .window_chip_select_n(cs_n),
    .window_chip_select_oe());
  ext_mem_model mem_u (.clk_sys, .read_strobe_n(rd_n), .address_port_out(aout),
    .mux_data_port_in(port_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (notes.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // one request to region r, expectation noted
  task automatic access(input int r, input logic wr, input logic byt);
    logic [23:0] a;
    logic [15:0] w, e, m;
    int          n;
    a = base[r] | (24'($random(seed)) & ((r == 5) ? 24'h000FFF : 24'h00FFFF));
    a[0] = a[0] & byt;
    w = a[15:0] ^ 16'h5A3C;
    e = (r == 2) ? {w[7:0] ^ 8'h01, w[7:0]} : w;
    if (byt) e = {8'h00, (a[0] && r != 2) ? w[15:8] : w[7:0]};
    m = (wr || r == 5) ? 16'h0000 : (byt ? 16'h00FF : 16'hFFFF);
    n = 0;
    // one idle edge between requests, bounded wait
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (req_ready !== 1'b1) miscompares++;
    req_valid = 1'b1;
    req_addr = a;
    req_write = wr;
    req_byte = byt;
    req_wdata = 16'($random(seed));
    notes.push_back({r == 5, a[23:16], cse[r], m, e & m});
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : access
  ////////////////////////////////////////////////////////////////////////////////
  // result monitor against oldest note
  always @(negedge clk_sys) begin
    if (resp_valid === 1'b1) begin
      nt = notes.pop_front();
      check("internal", 16'(resp_int), 16'(nt[45]));
      check("rdata", rdata & nt[31:16], nt[15:0]);
      if (!nt[45]) begin
        check("chip select", 16'(cs_n), 16'(nt[36:32]));
        check("segment", 16'(seg_out), 16'(nt[44:37]));
      end
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
  initial begin
    seed = 32'hA423;
    {reset, req_valid, req_write, req_byte, bpd_we, wpc} = 6'h21;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    dflt = 5'h1C;
    wcfg = {5'h14, 5'h1D, 5'h18, 5'h1C};
    wbase = {12'h200, 12'h400, 12'h110, 12'h100};
    wmask = {12'hFF0, 12'hFF0, 12'hFF0, 12'hF00};
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    check("seg select", 16'(seg_sel), 16'h0002);
    check("cs count", 16'(csc), 16'h0003);
    check("byte disable", 16'(bpd), 16'h0000);
    for (int r = 0; r < 6; r++) begin
      access(r, 1'b0, 1'b0);
      access(r, 1'b1, 1'b1);
      access(r, 1'b0, 1'b1);
    end
    repeat (30) access($unsigned($random(seed)) % 6, 1'($random(seed)), 1'($random(seed)));
    // no demux anywhere; changed while idle
    repeat (12) @(negedge clk_sys);
    dflt = 5'h14;
    wcfg = {5'h14, 5'h15, 5'h10, 5'h14};
    wpc = 1'b0;
    for (int r = 0; r < 5; r++) begin
      access(r, 1'b0, 1'b0);
      access(r, 1'b1, 1'b1);
    end
    repeat (20) @(negedge clk_sys);
    bpd_we = 1'b1;
    @(negedge clk_sys);
    bpd_we = 1'b0;
    @(negedge clk_sys);
    check("byte disable", 16'(bpd), 16'h0001);
    finish_test();
  end
endmodule : external_bus_window_select_tb
`default_nettype wire
